// File: fmh_monitor.sv
// Front-end monitor: hit-count and dead-time histograms, pedestal offsets,
// equalization and zero-suppression threshold tables behind AXI4-Lite.
// Assumes event, trigger and sample inputs synchronous to ref_clk.
// Function
// - Count hits per ASIC each event, accumulate
// - Four hit histograms, 80 bins, 32 bits
// - Fixed-frame mode count is always 79
// - Selective mode count comes from hits
// - Clear or read one named ASIC histogram
// - Dead time from trigger to write-ready
// - One dead-time histogram, 1024 x 32
// - Two-bit readable dead-time resolution select
// - Out-of-range dead time goes to last bin
// - Round dead time to nearest unit
// - Full 32-bit bins saturate, never wrap
// - Clear and read whole dead-time histogram
// - Pedestal bins: 512, from programmable offset
// - Offset set and clear over ranges
// - Pedestal run keeps data local
// - Per-channel equalization and threshold tables
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module fmh_monitor #(
  parameter int NUM_ASIC = 4,
  parameter int HIT_BINS = 80,
  parameter int DEAD_BINS = 1024,
  parameter int NUM_CH = 128,
  parameter int ADC_W = 12
) (
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic ev_start, // Event frame begins
  input wire logic [NUM_ASIC-1:0] hit_strobe, // One channel hit per ASIC
  input wire logic ev_end, // Event frame ends
  input wire logic trig_valid, // Valid trigger received
  input wire logic sample_write_ready, // Ready to resume sampling
  input wire logic adc_valid, // Digitized sample valid
  input wire logic [1:0] adc_asic, // Sample ASIC
  input wire logic [6:0] adc_chan, // Sample channel
  input wire logic [ADC_W-1:0] adc_data, // Sample value
  output logic fwd_enable, // Data may go to acquisition
  output logic [8:0] ped_bin, // Pedestal bin index
  output logic ped_bin_valid, // Pedestal bin index valid
  output logic ped_clr, // Clear pedestal histograms
  output logic [17:0] ped_sel, // Range of that clear
  output logic [ADC_W-1:0] zs_eq, // Equalization of sample channel
  output logic [ADC_W-1:0] zs_thr // Threshold of sample channel
);
  import fmh_pkg::*;

  // Dead-time unit length in cycles
  function automatic logic [16:0] unit_cycles(input logic [1:0] code);
    unique case (code)
      2'd0: unit_cycles = DEAD_UNIT0_CYC;
      2'd1: unit_cycles = DEAD_UNIT1_CYC;
      2'd2: unit_cycles = DEAD_UNIT2_CYC;
      2'd3: unit_cycles = DEAD_UNIT3_CYC;
    endcase
  endfunction
  // Saturating histogram increment
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hffffffff) ? v : v + 32'h1;
  endfunction
  // Histogram memories, channel tables and registers
  logic [31:0] hit_hist [NUM_ASIC][HIT_BINS], dead_hist [DEAD_BINS];
  logic [ADC_W-1:0] eq_tab [NUM_ASIC][NUM_CH], thr_tab [NUM_ASIC][NUM_CH];
  logic [ADC_W-1:0] off_tab [NUM_ASIC][NUM_CH];
  logic [3:0] ctrl_q;
  logic [8:0] hit_ptr_q, ch_ptr_q, ped_bin_q;
  logic [9:0] dead_ptr_q;
  logic [17:0] ped_sel_q;
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q, ped_clr_q, ped_bin_valid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [6:0] hit_cnt_q [NUM_ASIC], hit_cnt_d [NUM_ASIC], hit_bin [NUM_ASIC];
  fmh_dstate_t dstate_q;
  logic [16:0] sub_q;
  logic [10:0] unit_q;
  logic [ADC_W-1:0] zs_eq_q, zs_thr_q;
  // Write decode
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire wr_ctrl = wr_fire & (awaddr_q == REG_CTRL);
  wire wr_cmd = wr_fire & (awaddr_q == REG_CMD);
  wire wr_eq = wr_fire & (awaddr_q == REG_EQ);
  wire wr_thr = wr_fire & (awaddr_q == REG_THR);
  wire wr_off = wr_fire & (awaddr_q == REG_PED_OFF);
  wire wr_known = (awaddr_q <= REG_PED_OFF) & (awaddr_q[1:0] == 2'b00);
  wire hit_clr = wr_cmd & wdata_q[CMD_HIT_CLR_BIT];
  wire dead_clr = wr_cmd & wdata_q[CMD_DEAD_CLR_BIT];
  wire [1:0] clr_asic = wdata_q[1:0];
  wire [1:0] resol = ctrl_q[CTRL_RESOL_LSB +: 2];
  wire fixed_mode = ctrl_q[CTRL_FIXED_BIT];
  wire ped_run = ctrl_q[CTRL_PEDRUN_BIT];
  wire [1:0] ch_asic = ch_ptr_q[8:7];
  wire [6:0] ch_idx = ch_ptr_q[6:0];
  wire [1:0] sel_alo = ped_sel_q[1:0];
  wire [1:0] sel_ahi = ped_sel_q[3:2];
  wire [6:0] sel_clo = ped_sel_q[10:4];
  wire [6:0] sel_chi = ped_sel_q[17:11];
  // Bus handshakes
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  // Write channel capture and response
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_q)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end
  // Control registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RESET;
      hit_ptr_q <= 9'h0;
      dead_ptr_q <= 10'h0;
      ch_ptr_q <= 9'h0;
      ped_sel_q <= 18'h0;
      ped_clr_q <= 1'b0;
    end
    else
    begin
      ped_clr_q <= wr_cmd & wdata_q[CMD_PED_CLR_BIT];
      if (wr_ctrl && s_axi_wstrb[0])
        ctrl_q <= wdata_q[3:0];
      if (wr_fire && awaddr_q == REG_HIT_PTR)
        hit_ptr_q <= wdata_q[8:0];
      if (wr_fire && awaddr_q == REG_DEAD_PTR)
        dead_ptr_q <= wdata_q[9:0];
      if (wr_fire && awaddr_q == REG_CH_PTR)
        ch_ptr_q <= wdata_q[8:0];
      if (wr_fire && awaddr_q == REG_PED_SEL)
        ped_sel_q <= wdata_q[17:0];
    end
  end
  // Read data selection
  logic [31:0] rd_mux;
  wire [1:0] rd_hit_asic = hit_ptr_q[8:7];
  wire [6:0] rd_hit_bin = hit_ptr_q[6:0];
  wire rd_known = (s_axi_araddr <= REG_STATUS) & (s_axi_araddr[1:0] == 2'b00);
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (s_axi_araddr)
      REG_CTRL: rd_mux = {28'h0, ctrl_q};
      REG_HIT_PTR: rd_mux = {23'h0, hit_ptr_q};
      REG_HIT_DATA: rd_mux = (rd_hit_bin < HIT_BINS) ?
        hit_hist[rd_hit_asic][rd_hit_bin] : 32'h0;
      REG_DEAD_PTR: rd_mux = {22'h0, dead_ptr_q};
      REG_DEAD_DATA: rd_mux = dead_hist[dead_ptr_q];
      REG_CH_PTR: rd_mux = {23'h0, ch_ptr_q};
      REG_EQ: rd_mux = 32'(eq_tab[ch_asic][ch_idx]);
      REG_THR: rd_mux = 32'(thr_tab[ch_asic][ch_idx]);
      REG_PED_SEL: rd_mux = {14'h0, ped_sel_q};
      REG_PED_OFF: rd_mux = 32'(off_tab[ch_asic][ch_idx]);
      REG_STATUS: rd_mux = {31'h0, dstate_q == FMH_MEAS};
      default: rd_mux = 32'h0;
    endcase
  end
  // Read channel
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= AXI_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_known ? AXI_OKAY : AXI_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end
  // Per-ASIC hit counting, saturating at the top bin
  for (genvar a = 0; a < NUM_ASIC; a++)
  begin : g_hit
    wire [6:0] base = ev_start ? 7'h0 : hit_cnt_q[a];
    assign hit_cnt_d[a] = (hit_strobe[a] && base != FIXED_FRAME_HITS) ?
      base + 7'h1 : base;
    assign hit_bin[a] = fixed_mode ? FIXED_FRAME_HITS : hit_cnt_d[a];
    always_ff @(posedge ref_clk or negedge rstn)
    begin
      if (!rstn)
        hit_cnt_q[a] <= 7'h0;
      else
        hit_cnt_q[a] <= ev_end ? 7'h0 : hit_cnt_d[a];
    end
  end
  // Hit-count histograms; clear of the named ASIC wins
  always_ff @(posedge ref_clk)
  begin
    for (int a = 0; a < NUM_ASIC; a++)
    begin
      if (hit_clr && clr_asic == 2'(a))
      begin
        for (int b = 0; b < HIT_BINS; b++)
          hit_hist[a][b] <= 32'h0;
      end
      else if (ev_end)
        hit_hist[a][hit_bin[a]] <= sat_inc(hit_hist[a][hit_bin[a]]);
    end
  end
  // Dead-time measurement
  wire [16:0] unit_len = unit_cycles(resol);
  wire sub_wrap = (sub_q == unit_len - 17'h1);
  wire round_up = (sub_q >= {1'b0, unit_len[16:1]});
  wire [10:0] rounded = unit_q + {10'h0, round_up};
  wire [9:0] dead_bin = (rounded >= DEAD_LAST_BIN) ?
    DEAD_LAST_BIN[9:0] : rounded[9:0];
  wire dead_done = (dstate_q == FMH_MEAS) & sample_write_ready;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dstate_q <= FMH_IDLE;
      sub_q <= 17'h0;
      unit_q <= 11'h0;
    end
    else
    begin
      unique case (dstate_q)
        FMH_IDLE:
          if (trig_valid)
          begin
            dstate_q <= FMH_MEAS;
            sub_q <= 17'h0;
            unit_q <= 11'h0;
          end
        FMH_MEAS:
          if (sample_write_ready)
            dstate_q <= FMH_IDLE;
          else if (sub_wrap)
          begin
            sub_q <= 17'h0;
            if (unit_q != DEAD_LAST_BIN)
              unit_q <= unit_q + 11'h1;
          end
          else
            sub_q <= sub_q + 17'h1;
      endcase
    end
  end
  // Dead-time histogram; whole clear wins
  always_ff @(posedge ref_clk)
  begin
    if (dead_clr)
    begin
      for (int b = 0; b < DEAD_BINS; b++)
        dead_hist[b] <= 32'h0;
    end
    else if (dead_done)
      dead_hist[dead_bin] <= sat_inc(dead_hist[dead_bin]);
  end
  // Channel tables: single-channel and ranged writes
  always_ff @(posedge ref_clk)
  begin
    if (wr_eq)
      eq_tab[ch_asic][ch_idx] <= wdata_q[ADC_W-1:0];
    if (wr_thr)
      thr_tab[ch_asic][ch_idx] <= wdata_q[ADC_W-1:0];
    for (int a = 0; a < NUM_ASIC; a++)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (wr_off && 2'(a) >= sel_alo && 2'(a) <= sel_ahi &&
            7'(c) >= sel_clo && 7'(c) <= sel_chi)
          off_tab[a][c] <= wdata_q[ADC_W-1:0];
      end
    end
  end
  // Pedestal binning and zero-suppression lookup
  wire [ADC_W-1:0] samp_off = off_tab[adc_asic][adc_chan];
  wire [ADC_W-1:0] samp_diff = adc_data - samp_off;
  wire in_ped = (adc_data >= samp_off) & (samp_diff <= ADC_W'(PED_BINS_M1));
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ped_bin_q <= 9'h0;
      ped_bin_valid_q <= 1'b0;
      zs_eq_q <= '0;
      zs_thr_q <= '0;
    end
    else
    begin
      ped_bin_valid_q <= adc_valid & ped_run & in_ped;
      ped_bin_q <= samp_diff[8:0];
      if (adc_valid)
      begin
        zs_eq_q <= eq_tab[adc_asic][adc_chan];
        zs_thr_q <= thr_tab[adc_asic][adc_chan];
      end
    end
  end
  // Outputs
  assign fwd_enable = ~ped_run;
  assign ped_bin = ped_bin_q;
  assign ped_bin_valid = ped_bin_valid_q;
  assign ped_clr = ped_clr_q;
  assign ped_sel = ped_sel_q;
  assign zs_eq = zs_eq_q;
  assign zs_thr = zs_thr_q;
endmodule // fmh_monitor
`default_nettype wire

// File: fmh_pkg.sv
// Constants, register map and types of the front-end monitor histograms.
// Assumes a 100 MHz ref_clk and a 32-bit AXI4-Lite register bus.
`default_nettype none
package fmh_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int DEAD_UNIT0_NS = 1000;
  localparam int DEAD_UNIT1_NS = 10000;
  localparam int DEAD_UNIT2_NS = 100000;
  localparam int DEAD_UNIT3_NS = 1000000;
  localparam logic [16:0] DEAD_UNIT0_CYC = 17'(DEAD_UNIT0_NS / CLK_PERIOD_NS);
  localparam logic [16:0] DEAD_UNIT1_CYC = 17'(DEAD_UNIT1_NS / CLK_PERIOD_NS);
  localparam logic [16:0] DEAD_UNIT2_CYC = 17'(DEAD_UNIT2_NS / CLK_PERIOD_NS);
  localparam logic [16:0] DEAD_UNIT3_CYC = 17'(DEAD_UNIT3_NS / CLK_PERIOD_NS);
  // Histogram geometry
  localparam logic [6:0] FIXED_FRAME_HITS = 7'd79;
  localparam logic [10:0] DEAD_LAST_BIN = 11'h3ff;
  localparam logic [9:0] PED_BINS_M1 = 10'h1ff;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_HIT_PTR = 8'h08;
  localparam logic [7:0] REG_HIT_DATA = 8'h0c;
  localparam logic [7:0] REG_DEAD_PTR = 8'h10;
  localparam logic [7:0] REG_DEAD_DATA = 8'h14;
  localparam logic [7:0] REG_CH_PTR = 8'h18;
  localparam logic [7:0] REG_EQ = 8'h1c;
  localparam logic [7:0] REG_THR = 8'h20;
  localparam logic [7:0] REG_PED_SEL = 8'h24;
  localparam logic [7:0] REG_PED_OFF = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2c;
  // Field positions
  localparam int CTRL_FIXED_BIT = 0;
  localparam int CTRL_RESOL_LSB = 1;
  localparam int CTRL_PEDRUN_BIT = 3;
  localparam int CMD_HIT_CLR_BIT = 4;
  localparam int CMD_DEAD_CLR_BIT = 5;
  localparam int CMD_PED_CLR_BIT = 6;
  // Reset values and bus response codes
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // Dead-time measurement states
  typedef enum logic {FMH_IDLE = 1'b0, FMH_MEAS = 1'b1} fmh_dstate_t;
endpackage
`default_nettype wire

// File: fmh_monitor_properties.sv
// Checker of bus handshakes and pedestal outputs of the monitor block.
// Assumes binding to fmh_monitor; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module fmh_props (
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic s_axi_awvalid, // Wr addr valid
  input wire logic s_axi_awready, // Wr addr ready
  input wire logic s_axi_wvalid, // Wr data valid
  input wire logic s_axi_wready, // Wr data ready
  input wire logic s_axi_bvalid, // Wr resp valid
  input wire logic s_axi_bready, // Wr resp ready
  input wire logic s_axi_arvalid, // Rd addr valid
  input wire logic s_axi_arready, // Rd addr ready
  input wire logic s_axi_rvalid, // Rd data valid
  input wire logic s_axi_rready, // Rd data ready
  input wire logic adc_valid, // Sample valid
  input wire logic fwd_enable, // Forwarding on
  input wire logic ped_bin_valid, // Bin index valid
  input wire logic ped_clr // Pedestal clear
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Read answered one cycle on, write two cycles on; both released on acceptance
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("Write not answered");
  property p_b_close;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_close: assert property (p_b_close) else $error("Write answer kept");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("Read not answered");
  property p_r_close;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_close: assert property (p_r_close) else $error("Read answer kept");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("Read taken while busy");
  // Pedestal outputs
  property p_ped_pulse;
    ped_clr |=> !ped_clr;
  endproperty
  a_ped_pulse: assert property (p_ped_pulse) else $error("Clear pulse too long");
  property p_ped_local;
    ped_bin_valid |-> !fwd_enable;
  endproperty
  a_ped_local: assert property (p_ped_local) else $error("Data forwarded in run");
  property p_ped_cause;
    ped_bin_valid |-> $past(adc_valid);
  endproperty
  a_ped_cause: assert property (p_ped_cause) else $error("Bin without sample");
endmodule // fmh_props
bind fmh_monitor fmh_props i_props (.ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .adc_valid, .fwd_enable,
  .ped_bin_valid, .ped_clr);
`default_nettype wire

// File: fmh_be_master.sv
// Back-end master model: AXI4-Lite register access tasks.
// Assumes a slave on ref_clk that answers before the bench timeout.
`timescale 1ns/1ns
`default_nettype none
module fmh_be_master (
  input wire logic ref_clk, // Clock
  output logic [7:0] s_axi_awaddr, // Wr addr
  output logic s_axi_awvalid, // Wr addr valid
  input wire logic s_axi_awready, // Wr addr ready
  output logic [31:0] s_axi_wdata, // Wr data
  output logic [3:0] s_axi_wstrb, // Strobes
  output logic s_axi_wvalid, // Wr data valid
  input wire logic s_axi_wready, // Wr data ready
  input wire logic [1:0] s_axi_bresp, // Wr resp
  input wire logic s_axi_bvalid, // Wr resp valid
  output logic s_axi_bready, // Wr resp ready
  output logic [7:0] s_axi_araddr, // Rd addr
  output logic s_axi_arvalid, // Rd addr valid
  input wire logic s_axi_arready, // Rd addr ready
  input wire logic [31:0] s_axi_rdata, // Rd data
  input wire logic [1:0] s_axi_rresp, // Rd resp
  input wire logic s_axi_rvalid, // Rd data valid
  output logic s_axi_rready // Rd resp ready
);
  // Idle bus at time zero
  initial
  begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Write: both halves offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_open || w_open)
    begin
      @(posedge ref_clk);
      if (aw_open && s_axi_awready)
      begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w_open && s_axi_wready)
      begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read: address held until taken, data taken with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // fmh_be_master
`default_nettype wire

// File: tb.sv
// Self-checking bench of the front-end monitor histograms.
// Assumes fmh_pkg, fmh_monitor, fmh_be_master and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
  import fmh_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [3:0] hit_strobe = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ev_start = 1'b0, ev_end = 1'b0, trig_valid = 1'b0, sample_write_ready = 1'b0;
  logic adc_valid = 1'b0, fwd_enable, ped_bin_valid, ped_clr;
  logic [1:0] adc_asic = 2'd0;
  logic [6:0] adc_chan = 7'd0;
  logic [11:0] adc_data = 12'h000, zs_eq, zs_thr;
  logic [8:0] ped_bin;
  logic [17:0] ped_sel;
  int errors = 0;
  int total_checks = 0;
  int clr_seen = 0;
  always #5 ref_clk = ~ref_clk;
  fmh_monitor i_dut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev_start, .hit_strobe, .ev_end,
    .trig_valid, .sample_write_ready, .adc_valid, .adc_asic, .adc_chan, .adc_data,
    .fwd_enable, .ped_bin, .ped_bin_valid, .ped_clr, .ped_sel, .zs_eq, .zs_thr);
  fmh_be_master i_be (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Count pedestal clear pulses
  always @(posedge ref_clk)
    if (ped_clr === 1'b1) clr_seen <= clr_seen + 1;
  task automatic results();
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    i_be.wr(a, d, resp);
    `CHK("bresp", AXI_OKAY, resp)
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    i_be.rd(a, rdat, resp);
    `CHK("rdata", e, rdat)
  endtask
  task automatic hchk(input logic [1:0] a, input logic [6:0] b, input logic [31:0] e);
    wreg(REG_HIT_PTR, 32'({a, b}));
    rchk(REG_HIT_DATA, e);
  endtask
  // One event with n hits on every ASIC in mask
  task automatic hit_event(input int n, input logic [3:0] mask);
    @(posedge ref_clk) ev_start <= 1'b1;
    @(posedge ref_clk) ev_start <= 1'b0;
    repeat (n) @(posedge ref_clk) hit_strobe <= mask;
    @(posedge ref_clk) hit_strobe <= 4'h0;
    ev_end <= 1'b1;
    @(posedge ref_clk) ev_end <= 1'b0;
  endtask
  // Trigger, status read, wait, then ready to sample again
  task automatic dead_run(input int c);
    @(posedge ref_clk) trig_valid <= 1'b1;
    @(posedge ref_clk) trig_valid <= 1'b0;
    rchk(REG_STATUS, 32'h1);
    repeat (c) @(posedge ref_clk);
    sample_write_ready <= 1'b1;
    @(posedge ref_clk) sample_write_ready <= 1'b0;
  endtask
  task automatic sample(input logic [11:0] d, input logic v, input logic [8:0] b);
    @(posedge ref_clk);
    adc_valid <= 1'b1;
    adc_asic <= 2'd1;
    adc_chan <= 7'd5;
    adc_data <= d;
    @(posedge ref_clk) adc_valid <= 1'b0;
    #1;
    `CHK("ped_bin_valid", v, ped_bin_valid)
    if (v) `CHK("ped_bin", b, ped_bin)
  endtask
  // Hang guard
  initial
  begin
    #200000;
    errors++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wreg(REG_CTRL, 32'(c << CTRL_RESOL_LSB));
      rchk(REG_CTRL, 32'(c << CTRL_RESOL_LSB));
    end
    i_be.rd(8'h30, rdat, resp);
    `CHK("rresp", AXI_SLVERR, resp)
    i_be.wr(8'h34, 32'h1, resp);
    `CHK("bresp", AXI_SLVERR, resp)
    for (int a = 0; a < 4; a++)
      wreg(REG_CMD, 32'(a) | 32'h10);
    hit_event(5, 4'b0001);
    hit_event(5, 4'b0001);
    hchk(2'd0, 7'd5, 32'd2);
    hchk(2'd0, 7'd4, 32'd0);
    hchk(2'd1, 7'd0, 32'd2);
    wreg(REG_CMD, 32'h11);
    hchk(2'd1, 7'd0, 32'd0);
    hchk(2'd0, 7'd5, 32'd2);
    wreg(REG_CTRL, 32'h1);
    hit_event(3, 4'b0100);
    hchk(2'd2, 7'd79, 32'd1);
    hchk(2'd2, 7'd3, 32'd0);
    wreg(REG_CTRL, 32'h0);
    // Fixed-frame event above already put one count in bin 79 of ASIC 3
    hit_event(85, 4'b1000);
    hchk(2'd3, 7'd79, 32'd2);
    wreg(REG_CMD, 32'h20);
    dead_run(135);
    dead_run(155);
    dead_run(155);
    wreg(REG_DEAD_PTR, 32'd1);
    rchk(REG_DEAD_DATA, 32'd1);
    wreg(REG_DEAD_PTR, 32'd2);
    rchk(REG_DEAD_DATA, 32'd2);
    wreg(REG_PED_SEL, 32'h2855);
    `CHK("ped_sel", 18'h2855, ped_sel)
    wreg(REG_PED_OFF, 32'd3584);
    wreg(REG_CH_PTR, 32'h85);
    wreg(REG_EQ, 32'h123);
    wreg(REG_THR, 32'h2a5);
    rchk(REG_EQ, 32'h123);
    rchk(REG_THR, 32'h2a5);
    rchk(REG_PED_OFF, 32'd3584);
    wreg(REG_CTRL, 32'h8);
    `CHK("fwd_enable", 1'b0, fwd_enable)
    sample(12'd3594, 1'b1, 9'd10);
    `CHK("zs_eq", 12'h123, zs_eq)
    `CHK("zs_thr", 12'h2a5, zs_thr)
    sample(12'd3583, 1'b0, 9'd0);
    wreg(REG_CMD, 32'h40);
    repeat (2) @(posedge ref_clk);
    `CHK("ped_clr", 1, clr_seen)
    wreg(REG_CTRL, 32'h0);
    `CHK("fwd_enable", 1'b1, fwd_enable)
    results();
  end
endmodule // tb
`default_nettype wire
